/* File: shared/adcpp_pkg.sv */
// Shared constants and types for the converter host port
package adcpp_pkg;
	// ==========================================================
	// Data word
	localparam int DATA_W = 12;
	localparam int ADDR_HI_BIT = 11;
	localparam int ADDR_LO_BIT = 10;
	localparam int CTRL_FIELD_W = 10;
	// ==========================================================
	// Control registers (selected by data lines 11:10 on a write)
	localparam logic [1:0] CTRL0_IDX = 2'h0;
	localparam logic [1:0] CTRL1_IDX = 2'h1;
	localparam logic [9:0] CTRL0_RESET = 10'h000;
	localparam logic [9:0] CTRL1_RESET = 10'h000;
	// Control register 0 fields
	localparam int C0_EXT_REF_BIT = 0;
	localparam int C0_DIFF_BIT = 1;
	localparam int C0_SCAN_BIT = 2;
	localparam int C0_CHSEL_BIT = 3;
	// Control register 1 fields
	localparam int C1_STROBE_MODE_BIT = 0;
	// ==========================================================
	// Result queue
	localparam int QUEUE_DEPTH = 4;
	localparam int QUEUE_AW = 2;
	// ==========================================================
	// AXI4-Lite map (byte addresses)
	localparam logic [7:0] AXI_CTRL0_OFS = 8'h00;
	localparam logic [7:0] AXI_CTRL1_OFS = 8'h04;
	localparam logic [7:0] AXI_STATUS_OFS = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ADCPP_IDLE = 2'b00,
		ADCPP_READ = 2'b01,
		ADCPP_WRITE = 2'b10
	} adcpp_state_t;
	typedef struct packed {
		logic [11:0] code;
		logic chan_a;
	} adcpp_sample_t;
	typedef struct packed {
		logic cs_low_n;
		logic cs_high;
		logic wr_n;
		logic rd_n;
	} adcpp_strobe_t;
endpackage

/* File: design/adcpp_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module adcpp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	// ==========================================================
	// First stage feeds only the second
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* File: design/adcpp_host_port.sv */
// Parallel host port of a two-input 12-bit sampling converter
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Strobes count only while the low-true select is low and the high-true select is high.
// - Results appear as a 12-bit word on the data lines with line 0 the least significant.
// - On a control write, data lines 10 and 11 pick control register 0 or 1.
// - The channel marker is high whenever the driven word belongs to channel A.
// - Hardware reset returns every control field to its default.
// - The write pin acts as a read/write direction input or as a low-true write strobe.
// - The read strobe is used only in write-strobe mode, where low selects a data read.
// - A control register 0 bit selects internal or external reference.
// - Inputs are selectable singly and as two single-ended or one differential channel.
// - An auto-scan mode alternates results between the two inputs unaided.
// - Sampling is paced by the conversion clock, apart from the host strobes.
module adcpp_host_port (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic hw_reset_n_in,
	input wire logic conversion_clock_in,
	input wire logic [adcpp_pkg::DATA_W-1:0] sample_a_in,
	input wire logic [adcpp_pkg::DATA_W-1:0] sample_b_in,
	input wire logic select_low_true_n_in,
	input wire logic select_high_true_in,
	input wire logic wr_n_in,
	input wire logic rd_n_in,
	input wire logic [adcpp_pkg::DATA_W-1:0] data_in,
	output logic [adcpp_pkg::DATA_W-1:0] data_out,
	output logic data_oe_out,
	output logic chan_a_marker_out,
	output logic ext_ref_sel_out,
	output logic diff_mode_out,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import adcpp_pkg::*;

	// ==========================================================
	// Pin synchronisers
	localparam int SYNC_W = 2 * DATA_W + 4 + DATA_W + 2;
	logic [SYNC_W-1:0] pins_async;
	logic [SYNC_W-1:0] pins_s;
	adcpp_strobe_t strb;
	logic [DATA_W-1:0] din_s;
	logic [DATA_W-1:0] samp_a_s;
	logic [DATA_W-1:0] samp_b_s;
	logic cclk_s;
	logic hwrst_n_s;
	assign pins_async = {sample_a_in, sample_b_in, select_low_true_n_in, select_high_true_in,
		wr_n_in, rd_n_in, data_in, conversion_clock_in, hw_reset_n_in};
	adcpp_sync #(.WIDTH(SYNC_W)) u_sync (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.async_in(pins_async),
		.sync_out(pins_s)
	);
	assign {samp_a_s, samp_b_s, strb, din_s, cclk_s, hwrst_n_s} = pins_s;

	// ==========================================================
	// Control registers
	logic [CTRL_FIELD_W-1:0] ctrl0_r;
	logic [CTRL_FIELD_W-1:0] ctrl1_r;
	logic pin_wr_pulse;
	logic axi_wr_go;
	logic [7:0] axi_waddr;
	logic [31:0] axi_wdat;
	logic [3:0] wstrb_r;
	logic write_mode;
	logic scan_en;
	logic diff_en;
	logic ch_sel;
	assign write_mode = ctrl1_r[C1_STROBE_MODE_BIT];
	assign scan_en = ctrl0_r[C0_SCAN_BIT];
	assign diff_en = ctrl0_r[C0_DIFF_BIT];
	assign ch_sel = ctrl0_r[C0_CHSEL_BIT];

	// Pin writes win over a bus write in the same cycle
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || !hwrst_n_s) begin
			ctrl0_r <= CTRL0_RESET;
			ctrl1_r <= CTRL1_RESET;
		end else if (pin_wr_pulse) begin
			if (din_s[ADDR_HI_BIT:ADDR_LO_BIT] == CTRL0_IDX) begin
				ctrl0_r <= din_s[CTRL_FIELD_W-1:0];
			end else if (din_s[ADDR_HI_BIT:ADDR_LO_BIT] == CTRL1_IDX) begin
				ctrl1_r <= din_s[CTRL_FIELD_W-1:0];
			end
		end else if (axi_wr_go && wstrb_r[0] && wstrb_r[1]) begin
			if (axi_waddr == AXI_CTRL0_OFS) begin
				ctrl0_r <= axi_wdat[CTRL_FIELD_W-1:0];
			end else if (axi_waddr == AXI_CTRL1_OFS) begin
				ctrl1_r <= axi_wdat[CTRL_FIELD_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			ext_ref_sel_out <= 1'b0;
			diff_mode_out <= 1'b0;
		end else begin
			ext_ref_sel_out <= ctrl0_r[C0_EXT_REF_BIT];
			diff_mode_out <= diff_en;
		end
	end

	// ==========================================================
	// Sampling on conversion clock rising edges
	logic cclk_d_r;
	logic conv_tick;
	logic scan_phase_r;
	assign conv_tick = cclk_s && !cclk_d_r;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			cclk_d_r <= 1'b0;
		end else begin
			cclk_d_r <= cclk_s;
		end
	end

	// Result queue; oldest entry dropped on overflow to keep fresh data
	adcpp_sample_t queue_r [QUEUE_DEPTH];
	logic [QUEUE_AW-1:0] wptr_r;
	logic [QUEUE_AW-1:0] rptr_r;
	logic [QUEUE_AW:0] count_r;
	logic push;
	logic pop;
	adcpp_sample_t new_samp;
	logic new_is_a;
	always_comb begin
		new_is_a = 1'b1;
		if (diff_en) begin
			new_is_a = 1'b1;
		end else if (scan_en) begin
			new_is_a = !scan_phase_r;
		end else begin
			new_is_a = !ch_sel;
		end
		new_samp.code = new_is_a ? samp_a_s : samp_b_s;
		new_samp.chan_a = new_is_a;
	end
	assign push = conv_tick;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			scan_phase_r <= 1'b0;
		end else if (conv_tick) begin
			scan_phase_r <= scan_en && !diff_en && !scan_phase_r;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			queue_r[wptr_r] <= new_samp;
		end
	end
	logic full;
	assign full = (count_r == QUEUE_DEPTH[QUEUE_AW:0]);
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			wptr_r <= '0;
			rptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop || (push && full)) begin
				rptr_r <= rptr_r + 1'b1;
			end
			if (push && !pop && !full) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

	// ==========================================================
	// Host strobe decoding
	logic selected;
	logic read_act;
	logic write_act;
	logic read_act_d_r;
	logic write_act_d_r;
	assign selected = !strb.cs_low_n && strb.cs_high;
	always_comb begin
		read_act = 1'b0;
		write_act = 1'b0;
		if (selected) begin
			if (write_mode) begin
				write_act = !strb.wr_n;
				read_act = strb.wr_n && !strb.rd_n;
			end else begin
				read_act = strb.wr_n;
				write_act = !strb.wr_n;
			end
		end
	end
	// Direction mode has no strobe edge; select falling edge frames the access
	adcpp_state_t state_r;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state_r <= ADCPP_IDLE;
			read_act_d_r <= 1'b0;
			write_act_d_r <= 1'b0;
		end else begin
			read_act_d_r <= read_act;
			write_act_d_r <= write_act;
			case (state_r)
				ADCPP_IDLE: begin
					if (write_act) begin
						state_r <= ADCPP_WRITE;
					end else if (read_act) begin
						state_r <= ADCPP_READ;
					end
				end
				ADCPP_READ: begin
					if (!read_act) begin
						state_r <= ADCPP_IDLE;
					end
				end
				ADCPP_WRITE: begin
					if (!write_act) begin
						state_r <= ADCPP_IDLE;
					end
				end
				default: state_r <= ADCPP_IDLE;
			endcase
		end
	end
	// Write data is latched at the end of the strobe, when the host holds it stable
	assign pin_wr_pulse = (state_r == ADCPP_WRITE) && !write_act && write_act_d_r;
	// Result retires when the read ends
	assign pop = (state_r == ADCPP_READ) && !read_act && (count_r != '0);

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			data_out <= '0;
			data_oe_out <= 1'b0;
			chan_a_marker_out <= 1'b0;
		end else begin
			data_oe_out <= read_act;
			data_out <= (count_r != '0) ? queue_r[rptr_r].code : '0;
			chan_a_marker_out <= (count_r != '0) && queue_r[rptr_r].chan_a;
		end
	end

	// ==========================================================
	// AXI4-Lite slave: mirrors the control registers, status read-only
	logic aw_have_r;
	logic w_have_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	assign axi_waddr = awaddr_r;
	assign axi_wdat = wdata_r;
	assign axi_wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (axi_wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_r == AXI_CTRL0_OFS || awaddr_r == AXI_CTRL1_OFS) begin
					s_axi_bresp <= RESP_OKAY;
				end else begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				if (s_axi_araddr == AXI_CTRL0_OFS) begin
					s_axi_rdata <= {22'h0, ctrl0_r};
				end else if (s_axi_araddr == AXI_CTRL1_OFS) begin
					s_axi_rdata <= {22'h0, ctrl1_r};
				end else if (s_axi_araddr == AXI_STATUS_OFS) begin
					s_axi_rdata <= {26'h0, state_r, count_r, 1'b0};
				end else begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Checks
	a_bus_only_selected: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		data_oe_out |-> $past(selected)) else $error("data bus driven while not selected");
	a_unsel_no_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!selected |-> !write_act) else $error("write taken while not selected");
	a_read_drives_bus: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		read_act |=> data_oe_out) else $error("selected read did not drive bus");
	a_pop_advances: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(pop && !push) |=> (count_r == $past(count_r) - 1'b1))
		else $error("read did not retire a result");
	a_scan_alternates: assert property (@(posedge ref_clk_in)
		disable iff (!rst_n_in || !hwrst_n_s)
		(conv_tick && scan_en && !diff_en && $stable(ctrl0_r)) |=> scan_phase_r != $past(scan_phase_r))
		else $error("scan did not alternate");
	a_hwreset_clears: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!hwrst_n_s |=> (ctrl0_r == CTRL0_RESET && ctrl1_r == CTRL1_RESET))
		else $error("hardware reset left control set");
	a_rd_ignored_rw: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(!write_mode && selected && !strb.wr_n) |-> !read_act)
		else $error("read in direction mode while write");
	a_ref_follows: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		##1 ext_ref_sel_out == $past(ctrl0_r[C0_EXT_REF_BIT]))
		else $error("reference select mismatch");
endmodule
`default_nettype wire

/* File: test/adcpp_host_model.sv */
// Host bus model that drives the converter's parallel pins
`timescale 1ns/1ps
`default_nettype none
module adcpp_host_model (
	input wire logic clk_in,
	input wire logic [11:0] bus_in,
	input wire logic drv_in,
	input wire logic mark_in,
	output logic cs_n_out,
	output logic cs_h_out,
	output logic wr_n_out,
	output logic rd_n_out,
	output logic [11:0] d_out
);
	// ==========================================
	// Idle pins
	initial begin
		cs_n_out = 1'h1;
		cs_h_out = 1'h0;
		wr_n_out = 1'h1;
		rd_n_out = 1'h1;
		d_out = 12'h000;
	end
	// ==========================================
	// Accesses
	// Data held past the strobe, since the port latches late
	task automatic wr(input logic [11:0] v, input logic n0, input logic h1);
		@(posedge clk_in);
		cs_n_out <= n0;
		cs_h_out <= h1;
		wr_n_out <= 1'h0;
		d_out <= v;
		repeat (6) @(posedge clk_in);
		wr_n_out <= 1'h1;
		cs_n_out <= 1'h1;
		cs_h_out <= 1'h0;
		repeat (4) @(posedge clk_in);
		d_out <= ~v;
		repeat (2) @(posedge clk_in);
	endtask
	task automatic rd(input logic strb, input logic n0, input logic h1,
		output logic [11:0] v, output logic mk, output logic got);
		int n;
		got = 1'h0;
		v = 12'h000;
		mk = 1'h0;
		@(posedge clk_in);
		cs_n_out <= n0;
		cs_h_out <= h1;
		rd_n_out <= !strb;
		for (n = 0; n < 10 && !got; n++) begin
			@(posedge clk_in);
			got = drv_in;
		end
		if (got) begin
			@(posedge clk_in);
			v = bus_in;
			mk = mark_in;
		end
		rd_n_out <= 1'h1;
		cs_n_out <= 1'h1;
		cs_h_out <= 1'h0;
		repeat (5) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

/* File: test/adcpp_tb.sv */
// Self-checking bench for the converter host port
`timescale 1ns/1ps
`default_nettype none
module tb;
	import adcpp_pkg::*;
	logic clk, rst_n, hw_rst_n, cnv_ck;
	logic [11:0] sa, sb, dq, bus, hd, v, v2;
	logic doe, mk, csn, csh, wrn, rdn, xr, dm, m, m2, g;
	logic [7:0] awa, ara;
	logic awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
	logic [31:0] wd, rdt, d;
	logic [1:0] bresp, rresp, r;
	int n_errors = 0;
	int comparisons = 0;
	assign bus = doe ? dq : hd;
	adcpp_host_port dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .hw_reset_n_in(hw_rst_n),
		.conversion_clock_in(cnv_ck), .sample_a_in(sa), .sample_b_in(sb),
		.select_low_true_n_in(csn), .select_high_true_in(csh), .wr_n_in(wrn),
		.rd_n_in(rdn), .data_in(bus), .data_out(dq), .data_oe_out(doe),
		.chan_a_marker_out(mk), .ext_ref_sel_out(xr), .diff_mode_out(dm),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rre));
	adcpp_host_model host_u (.clk_in(clk), .bus_in(bus), .drv_in(doe), .mark_in(mk),
		.cs_n_out(csn), .cs_h_out(csh), .wr_n_out(wrn), .rd_n_out(rdn), .d_out(hd));
	// ==========================================
	// Helpers
	task chk(input string nm, input logic [31:0] e, input logic [31:0] gv);
		comparisons++;
		if (gv !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, gv);
		end
	endtask
	task give_verdict;
		if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
		int n;
		n = 0;
		awa <= a;
		wd <= dv;
		awv <= 1'h1;
		wv <= 1'h1;
		bre <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (awr) awv <= 1'h0;
			if (wr) wv <= 1'h0;
		end while (!bv && n < 50);
		rs = bresp;
		bre <= 1'h0;
		if (n >= 50) n_errors++;
		@(posedge clk);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
		int n;
		n = 0;
		ara <= a;
		arv <= 1'h1;
		rre <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (arr) arv <= 1'h0;
		end while (!rv && n < 50);
		dv = rdt;
		rs = rresp;
		rre <= 1'h0;
		if (n >= 50) n_errors++;
		@(posedge clk);
	endtask
	task automatic push(input logic [11:0] a, input logic [11:0] b);
		sa <= a;
		sb <= b;
		repeat (3) @(posedge clk);
		cnv_ck <= 1'h1;
		repeat (5) @(posedge clk);
		cnv_ck <= 1'h0;
		repeat (5) @(posedge clk);
	endtask
	// ==========================================
	// Scenarios
	task t_first;
		host_u.wr(12'h001, 1'h0, 1'h1);
		chk("ext_ref", 1, xr);
		host_u.wr(12'hc00, 1'h0, 1'h1);
		axi_rd(AXI_CTRL0_OFS, d, r);
		chk("ctrl0", 32'h1, d);
	endtask
	// Queue is empty here, so reads come back in push order
	task t_order;
		push(12'h801, 12'h3fe);
		host_u.wr(12'h000, 1'h1, 1'h1);
		host_u.wr(12'h000, 1'h0, 1'h0);
		chk("ext_unsel", 1, xr);
		host_u.rd(1'h0, 1'h1, 1'h1, v, m, g);
		chk("oe_cs_lo", 0, g);
		host_u.rd(1'h0, 1'h0, 1'h0, v, m, g);
		chk("oe_cs_hi", 0, g);
		push(12'h7f0, 12'h00f);
		host_u.rd(1'h0, 1'h0, 1'h1, v, m, g);
		chk("rd1", 12'h801, v);
		chk("mk1", 1, m);
		host_u.rd(1'h0, 1'h0, 1'h1, v, m, g);
		chk("rd2", 12'h7f0, v);
		chk("oe_idle", 0, doe);
	endtask
	task t_modes;
		host_u.wr(12'h009, 1'h0, 1'h1);
		push(12'h111, 12'h222);
		host_u.rd(1'h0, 1'h0, 1'h1, v, m, g);
		chk("chan_b", 12'h222, v);
		chk("mk_b", 0, m);
		host_u.wr(12'h002, 1'h0, 1'h1);
		chk("diff", 1, dm);
		chk("int_ref", 0, xr);
		push(12'h123, 12'h456);
		host_u.rd(1'h0, 1'h0, 1'h1, v, m, g);
		chk("mk_diff", 1, m);
		chk("v_diff", 12'h123, v);
	endtask
	task t_scan;
		host_u.wr(12'h004, 1'h0, 1'h1);
		push(12'h0a1, 12'h0b1);
		push(12'h0a2, 12'h0b2);
		host_u.rd(1'h0, 1'h0, 1'h1, v, m, g);
		host_u.rd(1'h0, 1'h0, 1'h1, v2, m2, g);
		chk("scan_mk", !m, m2);
		chk("scan_v1", m ? 12'h0a1 : 12'h0b1, v);
		chk("scan_v2", m ? 12'h0b2 : 12'h0a2, v2);
	endtask
	// Strobe mode: wr_n high alone must not start a read
	task t_strobe;
		host_u.wr(12'h000, 1'h0, 1'h1);
		host_u.wr(12'h401, 1'h0, 1'h1);
		push(12'h5a5, 12'h000);
		host_u.rd(1'h0, 1'h0, 1'h1, v, m, g);
		chk("rd_idle", 0, g);
		host_u.rd(1'h1, 1'h0, 1'h1, v, m, g);
		chk("rd_strb", 12'h5a5, v);
		host_u.wr(12'h001, 1'h0, 1'h1);
		chk("wr_strb", 1, xr);
	endtask
	task t_axi;
		axi_wr(AXI_CTRL0_OFS, 32'h2, r);
		chk("aw_resp", RESP_OKAY, r);
		chk("aw_diff", 1, dm);
		axi_wr(8'h0c, 32'h1, r);
		chk("aw_bad", RESP_SLVERR, r);
		axi_rd(8'h0c, d, r);
		chk("ar_bad", RESP_SLVERR, r);
		chk("ar_bad_d", 0, d);
		axi_rd(AXI_CTRL1_OFS, d, r);
		chk("ctrl1", 32'h1, d);
		chk("ar_resp", RESP_OKAY, r);
	endtask
	task t_hwrst;
		hw_rst_n <= 1'h0;
		repeat (5) @(posedge clk);
		hw_rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		chk("hw_diff", 0, dm);
		axi_rd(AXI_CTRL1_OFS, d, r);
		chk("hw_ctrl1", 0, d);
	endtask
	// Five pushes into four slots: the oldest sample is dropped
	task t_ovf;
		host_u.wr(12'h000, 1'h0, 1'h1);
		push(12'h0c1, 12'h000);
		push(12'h0c2, 12'h000);
		push(12'h0c3, 12'h000);
		push(12'h0c4, 12'h000);
		push(12'h0c5, 12'h000);
		host_u.rd(1'h0, 1'h0, 1'h1, v, m, g);
		chk("ovf_head", 12'h0c2, v);
		repeat (3) host_u.rd(1'h0, 1'h0, 1'h1, v, m, g);
		chk("ovf_tail", 12'h0c5, v);
		axi_rd(AXI_STATUS_OFS, d, r);
		chk("ovf_empty", 32'h0, d);
	endtask
	// ==========================================
	// Run
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		give_verdict;
	end
	initial begin
		rst_n = 1'h0;
		hw_rst_n = 1'h1;
		cnv_ck = 1'h0;
		sa = 12'h000;
		sb = 12'h000;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		{awv, wv, bre, arv, rre} = 5'h00;
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		chk("rst_oe", 0, doe);
		t_first;
		t_order;
		t_modes;
		t_scan;
		t_strobe;
		t_axi;
		t_hwrst;
		t_ovf;
		give_verdict;
	end
endmodule
`default_nettype wire
